// ### src/charger_cfg_pkg.sv
/*
 Constants, reset values, field positions and helpers for the charger
 configuration register group. Assumes a 200 MHz system clock.
*/
// Notes on behaviour
// - voltage code is 3500 mV plus 10 mV/count
// - applied charge voltage clamped to 3500..4770 mV
// - watchdog period off, 40, 80 or 160 s
// - termination allowed when enable bit set
// - overheat opens switch, rechecks, then recloses
// - safety timer runs during pre and fast charge
// - safety limit 7 h or 16 h
// - cold range current 50 or 20 percent
// - input threshold is offset plus 100 mV/count
// - detect request forced with input, self-clearing
// - safety timer half speed when slowed
// - disable bit turns battery switch off
// - delay bit selects immediate or 12.3 s off
// - warm range caps target at 4.1 V
// - reset enable bit allows battery switch reset
// - threshold is max of register and tracking
// - register reset restores defaults and safety timer
package charger_cfg_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_BASE = 8'h04;
   localparam logic [7:0] CFG_RST [4] = '{8'h8C, 8'h9F, 8'hA6, 8'h4C};
   // bits that also revert on watchdog expiry
   localparam logic [7:0] WD_GROUP [4] = '{8'hFF, 8'hBF, 8'h80, 8'hD4};
   localparam int VOLT_LSB = 1;
   localparam int TERM_BIT = 7;
   localparam int HOT_OFF_BIT = 6;
   localparam int WD_LSB = 4;
   localparam int TMR_EN_BIT = 3;
   localparam int TMR_LEN_BIT = 2;
   localparam int THERMAL_REG_THRESHOLD_BIT = 1;
   localparam int COLD_BIT = 0;
   localparam int BOOST_LSB = 4;
   localparam int VIN_LSB = 0;
   localparam int DET_BIT = 7;
   localparam int HALF_BIT = 6;
   localparam int DIS_BIT = 5;
   localparam int WARM_BIT = 4;
   localparam int DLY_BIT = 3;
   localparam int SWRST_BIT = 2;
   localparam int TRK_LSB = 0;
   // pin vector positions
   localparam int PIN_HOT = 0;
   localparam int PIN_VBUS = 1;
   localparam int PIN_PM = 2;
   localparam int PIN_COOL = 3;
   localparam int PIN_THERMAL_REG_THRESHOLD = 4;
   localparam int PIN_WARM = 5;
   localparam int PIN_COLD = 6;
   // ------------------------------------------------------------
   // analog figures in mV and percent
   // ------------------------------------------------------------
   localparam logic [13:0] VOLT_BASE_MV = 14'd3500;
   localparam logic [13:0] VOLT_STEP_MV = 14'd10;
   localparam logic [13:0] VOLT_MAX_MV = 14'd4770;
   localparam logic [13:0] WARM_CAP_MV = 14'd4100;
   localparam logic [13:0] VIN_STEP_MV = 14'd100;
   localparam logic [13:0] VIN_OFS_MV [4] = '{14'd3900, 14'd5900, 14'd7500, 14'd10500};
   localparam logic [13:0] TRK_MV [4] = '{14'd0, 14'd200, 14'd250, 14'd300};
   localparam logic [6:0] PCT_FULL = 7'd100;
   localparam logic [6:0] PCT_HALF = 7'd50;
   localparam logic [6:0] PCT_FIFTH = 7'd20;
   // ------------------------------------------------------------
   // times and counts
   // ------------------------------------------------------------
   localparam longint CLK_HZ = 200000000;
   localparam longint SHIP_MODE_DELAY_MS = 12300;
   localparam logic [31:0] SHIP_DELAY_CYCLES = 32'(SHIP_MODE_DELAY_MS * (CLK_HZ / 1000));
   localparam logic [31:0] SECOND_CYCLES = 32'(CLK_HZ);
   localparam logic [7:0] WD_S [4] = '{8'd0, 8'd40, 8'd80, 8'd160};
   localparam int SEC_PER_H = 3600;
   localparam logic [15:0] TMR_SHORT_S = 16'(7 * SEC_PER_H);
   localparam logic [15:0] TMR_LONG_S = 16'(16 * SEC_PER_H);

   function automatic logic [13:0] mv_max(input logic [13:0] a, input logic [13:0] b);
      return (a > b) ? a : b;
   endfunction

   function automatic logic [13:0] mv_min(input logic [13:0] a, input logic [13:0] b);
      return (a < b) ? a : b;
   endfunction
endpackage

// ### src/charger_config_registers.sv
/*
 Charger configuration register group with watchdog, safety timer and
 battery switch control. Assumes a byte register port driven by the
 serial management slave on the same clock, and raw analog status pins.
*/
`timescale 1ns/10ps
`default_nettype none
module charger_config_registers #(
   parameter logic [31:0] SECOND_CYCLES = charger_cfg_pkg::SECOND_CYCLES,
   parameter logic [31:0] SHIP_DELAY_CYCLES = charger_cfg_pkg::SHIP_DELAY_CYCLES
) (
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   input  wire logic        CE,
   input  wire logic        REG_WR,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   output logic      [7:0]  REG_RDATA,
   input  wire logic        REG_RESET,
   input  wire logic        WATCHDOG_RESTART,
   input  wire logic        CHARGE_ACTIVE,
   input  wire logic        DETECT_DONE,
   input  wire logic [13:0] BATTERY_MV,
   input  wire logic [1:0]  INPUT_VOLT_OFFSET_SELECT,
   input  wire logic [6:0]  STATUS_PINS,
   output logic      [13:0] CHARGE_VOLT_TARGET,
   output logic             TERM_ENABLE,
   output logic             THERMAL_REG_HIGH,
   output logic      [6:0]  CHARGE_CURRENT_PCT,
   output logic      [2:0]  BOOST_OUTPUT_CODE,
   output logic      [13:0] INPUT_VOLT_THRESHOLD,
   output logic             INPUT_LIMIT_DETECT_FORCE,
   output logic             BATTERY_SWITCH_ON,
   output logic             BATTERY_SWITCH_RESET_ENABLE,
   output logic             SAFETY_TIMER_EXPIRED,
   output logic             WATCHDOG_EXPIRED
);
   typedef enum logic [1:0] {SW_ON, SW_WAIT, SW_SHIP, SW_HOT} sw_state_e;

   logic        rst_s1;
   logic        rst_n;
   logic [6:0]  pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
   logic [6:0]  pin_s1_d, pin_s2_d, pin_s3_d, pin_d;
   logic [7:0]  cfg_q [4];
   logic [7:0]  cfg_d [4];
   logic [31:0] sec_cnt_q, sec_cnt_d;
   logic [7:0]  wd_cnt_q, wd_cnt_d;
   logic [15:0] tmr_cnt_q, tmr_cnt_d;
   logic        half_ph_q, half_ph_d;
   logic        tmr_exp_q, tmr_exp_d;
   logic [31:0] ship_cnt_q, ship_cnt_d;
   sw_state_e   sw_q, sw_d;
   logic [7:0]  rdata_q, rdata_d;
   logic [13:0] target_q, target_d;
   logic [13:0] vin_q, vin_d;
   logic [6:0]  pct_q, pct_d;
   logic        wd_exp_q, wd_exp_d;
   logic        sw_on_q, sw_on_d;
   logic        force_q, force_d;
   logic        sec_tick;
   logic        wr_hit;
   logic [7:0]  wd_lim;
   logic [15:0] tmr_lim;
   logic        run;
   logic        slow;
   logic        advance;
   logic        hot;
   logic [13:0] raw_mv;
   logic [13:0] vin_mv;
   logic [7:0]  c1, c2, c3, c4;

   assign c1 = cfg_q[0];
   assign c2 = cfg_q[1];
   assign c3 = cfg_q[2];
   assign c4 = cfg_q[3];

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // a bit only moves once stages two and three agree
   always_comb
   begin
      pin_s1_d = STATUS_PINS;
      pin_s2_d = pin_s1_q;
      pin_s3_d = pin_s2_q;
      pin_d = (~(pin_s2_q ^ pin_s3_q) & pin_s3_q) | ((pin_s2_q ^ pin_s3_q) & pin_q);
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_q <= 7'h00;
         pin_s2_q <= 7'h00;
         pin_s3_q <= 7'h00;
         pin_q <= 7'h00;
      end
      else if (CE)
      begin
         pin_s1_q <= pin_s1_d;
         pin_s2_q <= pin_s2_d;
         pin_s3_q <= pin_s3_d;
         pin_q <= pin_d;
      end
   end

   // ---------------------------------------------------------------
   // registers, timers and switch control
   // ---------------------------------------------------------------
   always_comb
   begin
      sec_tick = (sec_cnt_q == SECOND_CYCLES - 32'h1);
      sec_cnt_d = sec_tick ? 32'h0 : sec_cnt_q + 32'h1;
      hot = pin_q[charger_cfg_pkg::PIN_HOT];
      wr_hit = REG_WR && (REG_ADDR[7:2] == charger_cfg_pkg::ADDR_BASE[7:2]);

      wd_lim = charger_cfg_pkg::WD_S[c2[charger_cfg_pkg::WD_LSB +: 2]];
      wd_exp_d = 1'b0;
      wd_cnt_d = wd_cnt_q;
      if (REG_RESET || WATCHDOG_RESTART || wd_lim == 8'h00)
         wd_cnt_d = 8'h00;
      else if (sec_tick)
      begin
         if (wd_cnt_q >= wd_lim - 8'h1)
         begin
            wd_cnt_d = 8'h00;
            wd_exp_d = 1'b1;
         end
         else
            wd_cnt_d = wd_cnt_q + 8'h1;
      end

      for (int i = 0; i < 4; i++)
      begin
         cfg_d[i] = cfg_q[i];
         if (wr_hit && REG_ADDR[1:0] == 2'(i))
            cfg_d[i] = REG_WDATA;
         if (wd_exp_d)
            cfg_d[i] = (cfg_d[i] & ~charger_cfg_pkg::WD_GROUP[i])
                     | (charger_cfg_pkg::CFG_RST[i] & charger_cfg_pkg::WD_GROUP[i]);
         if (REG_RESET)
            cfg_d[i] = charger_cfg_pkg::CFG_RST[i];
      end
      // clear on detect done, a fresh request wins
      if (DETECT_DONE && !(wr_hit && REG_ADDR[1:0] == 2'h3 && REG_WDATA[charger_cfg_pkg::DET_BIT])
          && !REG_RESET)
         cfg_d[3][charger_cfg_pkg::DET_BIT] = 1'b0;

      // run in pre and fast charge
      run = c2[charger_cfg_pkg::TMR_EN_BIT] && CHARGE_ACTIVE;
      slow = c4[charger_cfg_pkg::HALF_BIT] && (pin_q[charger_cfg_pkg::PIN_PM]
             || pin_q[charger_cfg_pkg::PIN_COOL] || pin_q[charger_cfg_pkg::PIN_THERMAL_REG_THRESHOLD]);
      advance = sec_tick && run && (!slow || half_ph_q);
      half_ph_d = (sec_tick && run && slow) ? !half_ph_q : half_ph_q;
      tmr_lim = c2[charger_cfg_pkg::TMR_LEN_BIT] ? charger_cfg_pkg::TMR_LONG_S
                                                  : charger_cfg_pkg::TMR_SHORT_S;
      tmr_cnt_d = tmr_cnt_q;
      tmr_exp_d = tmr_exp_q;
      if (REG_RESET || !run)
      begin
         tmr_cnt_d = 16'h0;
         tmr_exp_d = 1'b0;
         half_ph_d = 1'b0;
      end
      else if (advance && !tmr_exp_q)
      begin
         tmr_cnt_d = tmr_cnt_q + 16'h1;
         tmr_exp_d = (tmr_cnt_d >= tmr_lim);
      end

      sw_d = sw_q;
      ship_cnt_d = 32'h0;
      case (sw_q)
         SW_ON:
            if (hot && c2[charger_cfg_pkg::HOT_OFF_BIT])
               sw_d = SW_HOT;
            else if (c4[charger_cfg_pkg::DIS_BIT])
               sw_d = c4[charger_cfg_pkg::DLY_BIT] ? SW_WAIT : SW_SHIP;
         SW_WAIT:
            if (!c4[charger_cfg_pkg::DIS_BIT])
               sw_d = SW_ON;
            else if (ship_cnt_q >= SHIP_DELAY_CYCLES - 32'h1)
               sw_d = SW_SHIP;
            else
               ship_cnt_d = ship_cnt_q + 32'h1;
         SW_SHIP:
            if (!c4[charger_cfg_pkg::DIS_BIT])
               sw_d = SW_ON;
         SW_HOT:
            if (!c2[charger_cfg_pkg::HOT_OFF_BIT] || (sec_tick && !hot))
               sw_d = SW_ON;
         default:
            sw_d = SW_ON;
      endcase
      sw_on_d = (sw_d == SW_ON) || (sw_d == SW_WAIT);

      raw_mv = charger_cfg_pkg::VOLT_BASE_MV
             + charger_cfg_pkg::VOLT_STEP_MV * {7'h00, c1[charger_cfg_pkg::VOLT_LSB +: 7]};
      target_d = charger_cfg_pkg::mv_max(charger_cfg_pkg::VOLT_BASE_MV,
                 charger_cfg_pkg::mv_min(raw_mv, charger_cfg_pkg::VOLT_MAX_MV));
      if (pin_q[charger_cfg_pkg::PIN_WARM] && !c4[charger_cfg_pkg::WARM_BIT])
         target_d = charger_cfg_pkg::mv_min(target_d, charger_cfg_pkg::WARM_CAP_MV);

      vin_mv = charger_cfg_pkg::VIN_OFS_MV[INPUT_VOLT_OFFSET_SELECT]
             + charger_cfg_pkg::VIN_STEP_MV * {10'h000, c3[charger_cfg_pkg::VIN_LSB +: 4]};
      vin_d = vin_mv;
      if (c4[charger_cfg_pkg::TRK_LSB +: 2] != 2'h0)
         vin_d = charger_cfg_pkg::mv_max(vin_mv,
                 BATTERY_MV + charger_cfg_pkg::TRK_MV[c4[charger_cfg_pkg::TRK_LSB +: 2]]);

      pct_d = charger_cfg_pkg::PCT_FULL;
      if (pin_q[charger_cfg_pkg::PIN_COLD])
         pct_d = c2[charger_cfg_pkg::COLD_BIT] ? charger_cfg_pkg::PCT_FIFTH
                                               : charger_cfg_pkg::PCT_HALF;

      force_d = c4[charger_cfg_pkg::DET_BIT] && pin_q[charger_cfg_pkg::PIN_VBUS];

      // unmapped addresses read zero
      rdata_d = (REG_ADDR[7:2] == charger_cfg_pkg::ADDR_BASE[7:2]) ? cfg_q[REG_ADDR[1:0]]
                                                                   : 8'h00;
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_q <= charger_cfg_pkg::CFG_RST;
         sec_cnt_q <= 32'h0;
         wd_cnt_q <= 8'h00;
         tmr_cnt_q <= 16'h0;
         half_ph_q <= 1'b0;
         tmr_exp_q <= 1'b0;
         ship_cnt_q <= 32'h0;
         sw_q <= SW_ON;
         rdata_q <= 8'h00;
         target_q <= 14'h0000;
         vin_q <= 14'h0000;
         pct_q <= 7'h00;
         wd_exp_q <= 1'b0;
         sw_on_q <= 1'b1;
         force_q <= 1'b0;
      end
      else if (CE)
      begin
         cfg_q <= cfg_d;
         sec_cnt_q <= sec_cnt_d;
         wd_cnt_q <= wd_cnt_d;
         tmr_cnt_q <= tmr_cnt_d;
         half_ph_q <= half_ph_d;
         tmr_exp_q <= tmr_exp_d;
         ship_cnt_q <= ship_cnt_d;
         sw_q <= sw_d;
         rdata_q <= rdata_d;
         target_q <= target_d;
         vin_q <= vin_d;
         pct_q <= pct_d;
         wd_exp_q <= wd_exp_d;
         sw_on_q <= sw_on_d;
         force_q <= force_d;
      end
   end

   assign REG_RDATA = rdata_q;
   assign CHARGE_VOLT_TARGET = target_q;
   assign TERM_ENABLE = c2[charger_cfg_pkg::TERM_BIT];
   assign THERMAL_REG_HIGH = c2[charger_cfg_pkg::THERMAL_REG_THRESHOLD_BIT];
   assign CHARGE_CURRENT_PCT = pct_q;
   assign BOOST_OUTPUT_CODE = c3[charger_cfg_pkg::BOOST_LSB +: 3];
   assign INPUT_VOLT_THRESHOLD = vin_q;
   assign INPUT_LIMIT_DETECT_FORCE = force_q;
   assign BATTERY_SWITCH_ON = sw_on_q;
   assign BATTERY_SWITCH_RESET_ENABLE = c4[charger_cfg_pkg::SWRST_BIT];
   assign SAFETY_TIMER_EXPIRED = tmr_exp_q;
   assign WATCHDOG_EXPIRED = wd_exp_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!rst_n);

   property p_reg_reset;
      CE && REG_RESET |=> cfg_q[0] == 8'h8C && cfg_q[3][7:0] == 8'h4C;
   endproperty
   a_reg_reset: assert property (p_reg_reset) else $error("register reset missed");

   property p_clamp;
      target_q == 14'h0000 || (target_q >= 14'd3500 && target_q <= 14'd4770);
   endproperty
   a_clamp: assert property (p_clamp) else $error("target out of range");

   property p_wd_off;
      CE && c2[5:4] == 2'b00 |=> !wd_exp_q;
   endproperty
   a_wd_off: assert property (p_wd_off) else $error("disabled watchdog expired");

   property p_wd_group;
      CE && wd_exp_d && !REG_RESET && !REG_WR |=> $stable(cfg_q[2][6:0]) && c2[6] == $past(c2[6]);
   endproperty
   a_wd_group: assert property (p_wd_group) else $error("watchdog hit own-reset field");

   property p_det_clear;
      CE && DETECT_DONE && !REG_WR && !REG_RESET
      |=> !c4[7] ##1 (!INPUT_LIMIT_DETECT_FORCE || !$past(CE));
   endproperty
   a_det_clear: assert property (p_det_clear) else $error("detect bit not cleared");

   property p_ship_now;
      CE && sw_q == SW_ON && c4[5] && !c4[3] && !(hot && c2[6]) |=> !BATTERY_SWITCH_ON;
   endproperty
   a_ship_now: assert property (p_ship_now) else $error("switch not off at once");

   property p_ship_wait;
      CE && sw_q == SW_ON && c4[5] && c4[3] && !(hot && c2[6]) |=> BATTERY_SWITCH_ON;
   endproperty
   a_ship_wait: assert property (p_ship_wait) else $error("delayed switch off too early");

   property p_hot_off;
      CE && sw_q == SW_ON && hot && c2[6] |=> !BATTERY_SWITCH_ON && sw_q == SW_HOT;
   endproperty
   a_hot_off: assert property (p_hot_off) else $error("overheat did not open switch");

   property p_warm_cap;
      CE && pin_q[5] && !c4[4] |=> target_q <= 14'd4100;
   endproperty
   a_warm_cap: assert property (p_warm_cap) else $error("warm cap exceeded");

   property p_track;
      CE && c4[1:0] != 2'b00 |=> vin_q >= $past(BATTERY_MV) + 14'd200;
   endproperty
   a_track: assert property (p_track) else $error("tracking below battery");

   property p_tmr_exp;
      $rose(tmr_exp_q) |-> tmr_cnt_q == tmr_lim;
   endproperty
   a_tmr_exp: assert property (p_tmr_exp) else $error("safety expiry at wrong count");

   c_wd: cover property (wd_exp_q);
   c_ship: cover property (sw_q == SW_WAIT ##1 sw_q == SW_SHIP);
   c_hot: cover property (sw_q == SW_HOT ##1 sw_q == SW_ON);
   c_tmr: cover property ($rose(tmr_exp_q));
endmodule
`default_nettype wire

// ### tb/charger_config_registers_tb.sv
/*
 Self-checking bench for the charger configuration register group.
 Assumes the design's short-count parameters (10 cycles a second,
 20 cycles of switch-off delay) and a 200 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module charger_config_registers_tb;
   typedef struct packed {logic [3:0] sel; logic [15:0] val;} exp_s;
   localparam logic [7:0] DEF [4] = '{8'h8C, 8'h9F, 8'hA6, 8'h4C};
   localparam int OFS [4] = '{3900, 5900, 7500, 10500};
   logic        clk, reset_n, ce, reg_wr, reg_reset, wd_restart, charge_active, detect_done;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic [13:0] battery_mv, charge_volt_target, input_volt_threshold;
   logic [1:0]  ofs_sel;
   logic [6:0]  pins, charge_current_pct;
   logic [2:0]  boost_output_code;
   logic        term_enable, thermal_reg_high, detect_force, switch_on;
   logic        switch_reset_enable, safety_expired, watchdog_expired;
   logic [15:0] aux;
   exp_s        exp_q[$];
   int          errors = 0;
   int          checks = 0;
   // ------------------------------------------------------------
   // design and clock
   // ------------------------------------------------------------
   charger_config_registers #(.SECOND_CYCLES(32'd10), .SHIP_DELAY_CYCLES(32'd20)) DUT (
      .CLK(clk), .RESET_N(reset_n), .CE(ce), .REG_WR(reg_wr), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RESET(reg_reset),
      .WATCHDOG_RESTART(wd_restart), .CHARGE_ACTIVE(charge_active),
      .DETECT_DONE(detect_done), .BATTERY_MV(battery_mv),
      .INPUT_VOLT_OFFSET_SELECT(ofs_sel), .STATUS_PINS(pins),
      .CHARGE_VOLT_TARGET(charge_volt_target), .TERM_ENABLE(term_enable),
      .THERMAL_REG_HIGH(thermal_reg_high), .CHARGE_CURRENT_PCT(charge_current_pct),
      .BOOST_OUTPUT_CODE(boost_output_code), .INPUT_VOLT_THRESHOLD(input_volt_threshold),
      .INPUT_LIMIT_DETECT_FORCE(detect_force), .BATTERY_SWITCH_ON(switch_on),
      .BATTERY_SWITCH_RESET_ENABLE(switch_reset_enable),
      .SAFETY_TIMER_EXPIRED(safety_expired), .WATCHDOG_EXPIRED(watchdog_expired));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] obs(input logic [3:0] s);
      case (s)
         4'h0: return {8'h00, reg_rdata};
         4'h1: return {2'b00, charge_volt_target};
         4'h2: return {2'b00, input_volt_threshold};
         4'h3: return {15'h0000, switch_on};
         4'h4: return {15'h0000, watchdog_expired};
         4'h5: return {9'h000, charge_current_pct};
         4'h6: return {15'h0000, detect_force};
         4'h7: return {15'h0000, term_enable};
         4'h8: return {13'h0000, boost_output_code};
         4'h9: return {15'h0000, switch_reset_enable};
         4'hA: return {15'h0000, thermal_reg_high};
         4'hB: return {15'h0000, safety_expired};
         default: return aux;
      endcase
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic exp_out(input logic [3:0] s, input logic [15:0] v);
      exp_q.push_back('{sel: s, val: v});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      cyc(2);
      exp_out(4'h0, {8'h00, v});
   endtask
   task automatic strobe(input bit rst);
      @(posedge clk);
      if (rst) reg_reset <= 1'b1;
      else wd_restart <= 1'b1;
      @(posedge clk);
      reg_reset  <= 1'b0;
      wd_restart <= 1'b0;
   endtask
   // pulses seen within n cycles, sampled just after each edge
   task automatic count_pulses(input int n, output int c);
      c = 0;
      repeat (n)
      begin
         @(posedge clk);
         #1;
         if (watchdog_expired === 1'b1) c++;
      end
   endtask
   task automatic end_of_test;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
      begin
         $display("TB: PASS");
      end
      else
      begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // monitor and watchdog
   // ------------------------------------------------------------
   initial
   begin
      exp_s e;
      logic [15:0] got;
      forever
      begin
         @(negedge clk);
         while (exp_q.size() > 0)
         begin
            e = exp_q.pop_front();
            got = obs(e.sel);
            checks++;
            if (got !== e.val)
            begin
               errors++;
               $display("unexpected at %0t sel %h got %h expected %h", $time, e.sel, got, e.val);
            end
         end
      end
   end
   initial
   begin
      #200000;
      errors++;
      end_of_test();
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial
   begin
      int n;
      logic [6:0] code;
      logic [3:0] vin;
      reset_n = 1'b0; ce = 1'b1; reg_wr = 1'b0; reg_reset = 1'b0; wd_restart = 1'b0;
      charge_active = 1'b1; detect_done = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
      battery_mv = 14'd3000; ofs_sel = 2'b00; pins = 7'h00; aux = 16'h0000;
      n = $urandom(32'h1D7E);
      cyc(2);
      reset_n <= 1'b1;
      cyc(5);
      for (int i = 0; i < 4; i++) rd(8'h04 + 8'(i), DEF[i]);
      exp_out(4'h8, 16'h0002); exp_out(4'h9, 16'h0001); exp_out(4'h3, 16'h0001);
      rd(8'h08, 8'h00);
      wr(8'h03, 8'hFF);
      rd(8'h03, 8'h00);
      wr(8'h05, 8'h0D);
      cyc(3);
      exp_out(4'h7, 16'h0000); exp_out(4'hA, 16'h0000);
      rd(8'h05, 8'h0D);
      // watchdog off so it cannot disturb the later checks
      wr(8'h05, 8'h8F);
      cyc(3);
      exp_out(4'h7, 16'h0001);
      for (int i = 0; i < 8; i++)
      begin
         code = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : (i == 2) ? 7'h46 : 7'($urandom);
         wr(8'h04, {code, 1'(i)});
         cyc(3);
         exp_out(4'h1, 16'(3500 + 10 * int'(code)));
         rd(8'h04, {code, 1'(i)});
      end
      @(posedge clk) pins[5] <= 1'b1;
      wr(8'h04, 8'hFE);
      cyc(6);
      exp_out(4'h1, 16'd4100);
      wr(8'h07, 8'h5C);
      cyc(3);
      exp_out(4'h1, 16'd4770);
      wr(8'h07, 8'h4C);
      wr(8'h04, 8'h20);
      cyc(3);
      exp_out(4'h1, 16'd3660);
      @(posedge clk) pins <= 7'h40;
      cyc(6);
      exp_out(4'h5, 16'd20);
      wr(8'h05, 8'h8E);
      cyc(3);
      exp_out(4'h5, 16'd50);
      @(posedge clk) pins[6] <= 1'b0;
      cyc(6);
      exp_out(4'h5, 16'd100);
      wr(8'h05, 8'h8F);
      for (int o = 0; o < 4; o++)
      begin
         vin = 4'($urandom);
         @(posedge clk) ofs_sel <= 2'(o);
         wr(8'h06, {4'hA, vin});
         cyc(3);
         exp_out(4'h2, 16'(OFS[o] + 100 * int'(vin)));
      end
      @(posedge clk) ofs_sel <= 2'b00;
      battery_mv <= 14'd4500;
      wr(8'h06, 8'hA0);
      for (int t = 1; t < 4; t++)
      begin
         wr(8'h07, 8'h4C | 8'(t));
         cyc(3);
         // battery 4500 plus tracking beats the 3900 register threshold
         exp_out(4'h2, 16'(4650 + 50 * t));
      end
      @(posedge clk) battery_mv <= 14'd3000;
      cyc(3);
      exp_out(4'h2, 16'd3900);
      wr(8'h07, 8'h64);
      cyc(3);
      exp_out(4'h3, 16'h0000);
      wr(8'h07, 8'h4C);
      cyc(3);
      exp_out(4'h3, 16'h0001);
      wr(8'h07, 8'h6C);
      cyc(5);
      exp_out(4'h3, 16'h0001);
      cyc(25);
      exp_out(4'h3, 16'h0000);
      wr(8'h07, 8'h48);
      cyc(3);
      exp_out(4'h3, 16'h0001); exp_out(4'h9, 16'h0000);
      wr(8'h05, 8'hCF);
      @(posedge clk) pins[0] <= 1'b1;
      cyc(8);
      exp_out(4'h3, 16'h0000);
      @(posedge clk) pins[0] <= 1'b0;
      cyc(20);
      exp_out(4'h3, 16'h0001);
      wr(8'h05, 8'h8F);
      @(posedge clk) pins <= 7'h03;
      cyc(8);
      exp_out(4'h3, 16'h0001);
      wr(8'h07, 8'hCC);
      cyc(6);
      exp_out(4'h6, 16'h0001);
      rd(8'h07, 8'hCC);
      @(posedge clk) detect_done <= 1'b1;
      @(posedge clk) detect_done <= 1'b0;
      cyc(3);
      exp_out(4'h6, 16'h0000);
      rd(8'h07, 8'h4C);
      @(posedge clk) pins <= 7'h00;
      wr(8'h04, 8'h00); wr(8'h05, 8'h40); wr(8'h06, 8'h15); wr(8'h07, 8'h23);
      strobe(1'b1);
      for (int i = 0; i < 4; i++) rd(8'h04 + 8'(i), DEF[i]);
      exp_out(4'h3, 16'h0001);
      // clock enable low: a write must not land
      @(posedge clk) ce <= 1'b0;
      wr(8'h04, 8'h00);
      @(posedge clk) ce <= 1'b1;
      rd(8'h04, 8'h8C);
      for (int p = 1; p < 4; p++)
      begin
         wr(8'h05, 8'h8F | 8'(p << 4)); wr(8'h04, 8'h00); wr(8'h06, 8'h15); wr(8'h07, 8'h03);
         strobe(1'b0);
         n = 0;
         do
         begin
            @(posedge clk);
            #1;
            n++;
         end
         while (watchdog_expired !== 1'b1 && n < 2000);
         // free prescaler: expiry falls in the last second of the period
         aux = 16'((n >= 400 * (1 << (p - 1)) - 9) && (n <= 400 * (1 << (p - 1))));
         exp_out(4'hF, 16'h0001); exp_out(4'h4, 16'h0001);
         rd(8'h04, 8'h8C); rd(8'h05, 8'h9F); rd(8'h06, 8'h95); rd(8'h07, 8'h47);
      end
      // host keeps restarting inside the 40 s period
      wr(8'h05, 8'h9F);
      strobe(1'b0);
      aux = 16'h0000;
      repeat (4)
      begin
         count_pulses(300, n);
         aux = aux + 16'(n);
         strobe(1'b0);
      end
      wr(8'h05, 8'h8F);
      count_pulses(600, n);
      aux = aux + 16'(n);
      exp_out(4'hF, 16'h0000);
      // expiry needs hours of charge, out of reach here
      exp_out(4'hB, 16'h0000);
      cyc(2);
      end_of_test();
   end
endmodule
`default_nettype wire
